/* File: fbls_map.svh */
// Constants and rule summary for the flag-branch and load-store executor
//
// Function
// - Branch when interrupt enable is one
// - Branch when interrupt enable is zero
// - Carry clear/same-higher branch on C=0, lower on C=1
// - Negative branches on N=1, positive on N=0
// - Signed branches test N xor V
// - Half-carry branches test H set or clear
// - Register, pair and immediate moves: one cycle
// - Pointer load, post-increment form, two cycles
// - Pre-decrement load uses decremented pointer address
// - Displacement load from second/third pointer, unchanged
// - Direct load from instruction address, two cycles
// - Store through first pointer, optional post-increment
`ifndef FBLS_MAP_SVH
`define FBLS_MAP_SVH
// ----------------------------------------------------------------
// Register file layout
// ----------------------------------------------------------------
`define FBLS_NUM_REGS     32
`define FBLS_PTR1_LO      5'h1a
`define FBLS_PTR2_LO      5'h1c
`define FBLS_PTR3_LO      5'h1e
// ----------------------------------------------------------------
// Flag positions in the status byte
// ----------------------------------------------------------------
`define FBLS_FLAG_C       0
`define FBLS_FLAG_N       2
`define FBLS_FLAG_V       3
`define FBLS_FLAG_H       5
`define FBLS_FLAG_I       7
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FBLS_PC_RST       16'h0000
`define FBLS_REG_RST      8'h00
`endif

/* File: fbls_pkg.sv */
// Types shared by the flag-branch and load-store executor
package fbls_pkg;

  // Decoded operation codes supplied by the fetch stage
  typedef enum logic [4:0] {
    FBLS_OP_NOP     = 5'h00,
    FBLS_OP_BR_IE   = 5'h01,
    FBLS_OP_BR_ID   = 5'h02,
    FBLS_OP_BR_CC   = 5'h03,
    FBLS_OP_BR_SH   = 5'h04,
    FBLS_OP_BR_LO   = 5'h05,
    FBLS_OP_BR_NEG  = 5'h06,
    FBLS_OP_BR_POS  = 5'h07,
    FBLS_OP_BR_GE   = 5'h08,
    FBLS_OP_BR_LT   = 5'h09,
    FBLS_OP_BR_HS   = 5'h0a,
    FBLS_OP_BR_HC   = 5'h0b,
    FBLS_OP_COPY    = 5'h0c,
    FBLS_OP_PCOPY   = 5'h0d,
    FBLS_OP_IMM     = 5'h0e,
    FBLS_OP_LD_IND  = 5'h0f,
    FBLS_OP_LD_DISP = 5'h10,
    FBLS_OP_LD_DIR  = 5'h11,
    FBLS_OP_ST_IND  = 5'h12
  } fbls_op_t;

  // Pointer update modes for indirect access
  typedef enum logic [1:0] {
    FBLS_PM_PLAIN = 2'h0,
    FBLS_PM_POST  = 2'h1,
    FBLS_PM_PRE   = 2'h2
  } fbls_pmode_t;

  // One decoded instruction
  typedef struct packed {
    fbls_op_t    op;
    logic [4:0]  rd;
    logic [4:0]  rr;
    logic [1:0]  ptr;   // 0 first, 1 second, 2 third pointer
    fbls_pmode_t pmode;
    logic [7:0]  imm;   // Constant or displacement
    logic [15:0] addr;  // Direct address
    logic [6:0]  offs;  // Signed branch offset
  } fbls_instr_t;

  // Data memory request
  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fbls_mem_req_t;

  typedef enum logic [0:0] {
    FBLS_ST_EXEC = 1'b0,
    FBLS_ST_WAIT = 1'b1
  } fbls_state_t;

endpackage : fbls_pkg

/* File: fbls_regfile.sv */
// General purpose register file with three pointer-pair read views
`timescale 1ns/1ps
`include "fbls_map.svh"
module fbls_regfile
  import fbls_pkg::*;
#(
  parameter int NREG = `FBLS_NUM_REGS
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [4:0]        ra,
  input  wire logic [4:0]        rb,
  output logic      [7:0]        ra_data,
  output logic      [7:0]        rb_data,
  output logic      [15:0]       ptr1,
  output logic      [15:0]       ptr2,
  output logic      [15:0]       ptr3,
  input  wire logic              we0,
  input  wire logic [4:0]        wa0,
  input  wire logic [7:0]        wd0,
  input  wire logic              we1,
  input  wire logic [4:0]        wa1,
  input  wire logic [7:0]        wd1
);

  logic [7:0] regs_q [NREG];

  // ----------------------------------------------------------------
  // Storage; port 1 wins if both ports hit one register
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        regs_q[i] <= `FBLS_REG_RST;
      end else if (we1 && wa1 == 5'(i)) begin
        regs_q[i] <= wd1;
      end else if (we0 && wa0 == 5'(i)) begin
        regs_q[i] <= wd0;
      end
    end
  end

  // Reads are combinational: a copy or a store must see its source in
  // the cycle it is accepted, which a registered read cannot give
  assign ra_data = regs_q[ra];
  assign rb_data = regs_q[rb];

  // Pointer views combine adjacent pairs, low byte first
  assign ptr1 = {regs_q[`FBLS_PTR1_LO + 5'h01], regs_q[`FBLS_PTR1_LO]};
  assign ptr2 = {regs_q[`FBLS_PTR2_LO + 5'h01], regs_q[`FBLS_PTR2_LO]};
  assign ptr3 = {regs_q[`FBLS_PTR3_LO + 5'h01], regs_q[`FBLS_PTR3_LO]};

endmodule : fbls_regfile

/* File: fbls_exec.sv */
// Executor for flag branches, register moves, loads and pointer stores
`timescale 1ns/1ps
`include "fbls_map.svh"
module fbls_exec
  import fbls_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              instr_valid,
  input  wire fbls_instr_t       instr,
  input  wire logic [7:0]        sreg,
  input  wire logic [7:0]        mem_rdata,
  output logic                   instr_ready,
  output logic      [PC_W-1:0]   pc_q,
  output logic                   busy_q,
  output fbls_mem_req_t          mem_req_q,
  output logic      [7:0]        dbg_ra_q
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]  ra_data;
  logic [7:0]  rb_data;
  logic [15:0] ptr1;
  logic [15:0] ptr2;
  logic [15:0] ptr3;
  logic        we0;
  logic        we1;
  logic [4:0]  wa0;
  logic [4:0]  wa1;
  logic [7:0]  wd0;
  logic [7:0]  wd1;
  logic [4:0]  ra_sel;
  logic [4:0]  rb_sel;

  fbls_regfile #(
    .NREG (`FBLS_NUM_REGS)
  ) u_rf (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ra      (ra_sel),
    .rb      (rb_sel),
    .ra_data (ra_data),
    .rb_data (rb_data),
    .ptr1    (ptr1),
    .ptr2    (ptr2),
    .ptr3    (ptr3),
    .we0     (we0),
    .wa0     (wa0),
    .wd0     (wd0),
    .we1     (we1),
    .wa1     (wa1),
    .wd1     (wd1)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fbls_state_t   state_q;
  fbls_state_t   state_d;
  fbls_instr_t   hold_q;
  logic          rd_pend_q;
  logic          accept;
  logic          in_exec;

  assign in_exec     = (state_q == FBLS_ST_EXEC);
  assign instr_ready = in_exec;
  assign accept      = in_exec && instr_valid;

  // Flags taken from the status byte
  wire flag_c = sreg[`FBLS_FLAG_C];
  wire flag_n = sreg[`FBLS_FLAG_N];
  wire flag_v = sreg[`FBLS_FLAG_V];
  wire flag_h = sreg[`FBLS_FLAG_H];
  wire flag_i = sreg[`FBLS_FLAG_I];
  wire signed_lt = flag_n ^ flag_v;

  // Branch condition decode
  logic taken;
  always_comb begin
    unique case (instr.op)
      FBLS_OP_BR_IE:  taken = flag_i;
      FBLS_OP_BR_ID:  taken = !flag_i;
      FBLS_OP_BR_CC,
      FBLS_OP_BR_SH:  taken = !flag_c;
      FBLS_OP_BR_LO:  taken = flag_c;
      FBLS_OP_BR_NEG: taken = flag_n;
      FBLS_OP_BR_POS: taken = !flag_n;
      FBLS_OP_BR_GE:  taken = !signed_lt;
      FBLS_OP_BR_LT:  taken = signed_lt;
      FBLS_OP_BR_HS:  taken = flag_h;
      FBLS_OP_BR_HC:  taken = !flag_h;
      default:        taken = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Pointer selection and address forming
  // ----------------------------------------------------------------
  wire is_ld_ind  = instr.op == FBLS_OP_LD_IND;
  wire is_ld_disp = instr.op == FBLS_OP_LD_DISP;
  wire is_ld_dir  = instr.op == FBLS_OP_LD_DIR;
  wire is_st      = instr.op == FBLS_OP_ST_IND;
  wire is_load    = is_ld_ind || is_ld_disp || is_ld_dir;
  wire is_branch  = instr.op inside {[FBLS_OP_BR_IE:FBLS_OP_BR_HC]};
  wire two_cycle  = is_load || is_st || (is_branch && taken);

  // Store always goes through the first pointer
  logic [1:0]  ptr_idx;
  logic [15:0] ptr_val;
  logic [4:0]  ptr_lo;
  assign ptr_idx = is_st ? 2'h0 : instr.ptr;
  assign ptr_val = (ptr_idx == 2'h0) ? ptr1 :
                   (ptr_idx == 2'h1) ? ptr2 : ptr3;
  assign ptr_lo  = (ptr_idx == 2'h0) ? `FBLS_PTR1_LO :
                   (ptr_idx == 2'h1) ? `FBLS_PTR2_LO : `FBLS_PTR3_LO;

  // Displacement only allowed from second or third pointer
  wire [15:0] disp_base = instr.ptr[1] ? ptr3 : ptr2;
  wire [15:0] ptr_inc   = ptr_val + 16'h0001;
  wire [15:0] ptr_dec   = ptr_val - 16'h0001;
  wire        do_pre    = instr.pmode == FBLS_PM_PRE;
  wire        do_post   = instr.pmode == FBLS_PM_POST;

  logic [15:0] mem_addr;
  assign mem_addr = is_ld_dir  ? instr.addr :
                    is_ld_disp ? disp_base + {8'h00, instr.imm} :
                    do_pre     ? ptr_dec : ptr_val;

  // Pointer writeback: pre-decrement or post-increment, both bytes
  wire ptr_upd = accept && ((is_ld_ind && (do_pre || do_post)) ||
                 (is_st && do_post));
  wire [15:0] ptr_new = do_pre ? ptr_dec : ptr_inc;

  // ----------------------------------------------------------------
  // Register file write ports and read selection
  // ----------------------------------------------------------------
  // Sources are read in the accept cycle, so a copy lands at once and
  // a following op never sees a stale register
  assign ra_sel = instr.rr;
  assign rb_sel = instr.rr + 5'h01;

  wire do_copy  = accept && instr.op == FBLS_OP_COPY;
  wire do_pcopy = accept && instr.op == FBLS_OP_PCOPY;

  // Port 0: immediate, load data, copies, pointer low byte
  always_comb begin
    we0 = 1'b0;
    wa0 = 5'h00;
    wd0 = 8'h00;
    we1 = 1'b0;
    wa1 = 5'h00;
    wd1 = 8'h00;
    if (accept && instr.op == FBLS_OP_IMM) begin
      we0 = 1'b1;
      wa0 = instr.rd;
      wd0 = instr.imm;
    end else if (ptr_upd) begin
      we0 = 1'b1;
      wa0 = ptr_lo;
      wd0 = ptr_new[7:0];
      we1 = 1'b1;
      wa1 = ptr_lo + 5'h01;
      wd1 = ptr_new[15:8];
    end else if (do_copy || do_pcopy) begin
      we0 = 1'b1;
      wa0 = instr.rd;
      wd0 = ra_data;
      we1 = do_pcopy;
      wa1 = instr.rd + 5'h01;
      wd1 = rb_data;
    end else if (rd_pend_q) begin
      we0 = 1'b1;
      wa0 = hold_q.rd;
      wd0 = mem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing: moves finish in their issue slot; loads, stores and
  // taken branches hold the next slot, in which a new op is refused
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FBLS_ST_EXEC: if (accept && two_cycle) state_d = FBLS_ST_WAIT;
      FBLS_ST_WAIT: state_d = FBLS_ST_EXEC;
    endcase
  end

  wire [PC_W-1:0] offs_ext = PC_W'($signed(instr.offs));
  wire [PC_W-1:0] pc_next  = (accept && is_branch && taken) ?
                             pc_q + offs_ext + PC_W'(1) :
                             accept ? pc_q + PC_W'(1) : pc_q;

  // Core registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q   <= FBLS_ST_EXEC;
      pc_q      <= PC_W'(`FBLS_PC_RST);
      busy_q    <= 1'b0;
      rd_pend_q <= 1'b0;
      hold_q    <= '0;
      mem_req_q <= '0;
      dbg_ra_q  <= 8'h00;
    end else begin
      state_q   <= state_d;
      pc_q      <= pc_next;
      busy_q    <= (state_d == FBLS_ST_WAIT);
      rd_pend_q <= accept && is_load;
      hold_q    <= accept ? instr : hold_q;
      dbg_ra_q  <= ra_data;
      // Memory request one cycle; store data read from the register
      mem_req_q.rd_en <= accept && is_load;
      mem_req_q.wr_en <= accept && is_st;
      mem_req_q.addr  <= accept ? mem_addr : mem_req_q.addr;
      mem_req_q.wdata <= (accept && is_st) ? ra_data : mem_req_q.wdata;
    end
  end

endmodule : fbls_exec

/* File: fbls_exec_props.sv */
// Concurrent checks on the executor's ports
`timescale 1ns/1ps
module fbls_exec_props
  import fbls_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic            clock,
  input wire logic            sys_rst,
  input wire logic            instr_valid,
  input wire fbls_instr_t     instr,
  input wire logic [7:0]      sreg,
  input wire logic [7:0]      mem_rdata,
  input wire logic            instr_ready,
  input wire logic [PC_W-1:0] pc_q,
  input wire logic            busy_q,
  input wire fbls_mem_req_t   mem_req_q,
  input wire logic [7:0]      dbg_ra_q
);
  // ----------------------------------------------------------------
  // Decode of the offered instruction
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire            take  = instr_valid && instr_ready;
  wire            is_br = instr.op >= FBLS_OP_BR_IE &&
                          instr.op <= FBLS_OP_BR_HC;
  wire            is_ld = instr.op inside {FBLS_OP_LD_IND,
                          FBLS_OP_LD_DISP, FBLS_OP_LD_DIR};
  wire            nxv   = sreg[2] ^ sreg[3];
  // Condition bit per branch code, indexed by the code itself
  wire [11:0]     cond  = {!sreg[5], sreg[5], nxv, !nxv, !sreg[2],
                          sreg[2], sreg[0], !sreg[0], !sreg[0],
                          !sreg[7], sreg[7], 1'b0};
  wire            br_ok = is_br && cond[instr.op];
  wire [PC_W-1:0] nxt   = br_ok ? pc_q + 1'b1 +
                          {{(PC_W-7){instr.offs[6]}}, instr.offs} :
                          pc_q + 1'b1;

  a_reset_clears: assert property (disable iff (1'b0)
    sys_rst |=> pc_q == '0 && !busy_q && !mem_req_q.rd_en)
    else $error("state not cleared by reset");
  a_pc_next: assert property (take |=> pc_q == $past(nxt))
    else $error("program counter wrong after accept");
  a_branch_cycles: assert property (take && is_br
    |=> instr_ready == !$past(br_ok))
    else $error("branch cycle count wrong");
  a_load_pulse: assert property (take && is_ld |=>
    mem_req_q.rd_en && busy_q && !instr_ready ##1 !mem_req_q.rd_en)
    else $error("load strobe wrong");
  a_store_pulse: assert property (take &&
    instr.op == FBLS_OP_ST_IND |=>
    mem_req_q.wr_en && !mem_req_q.rd_en ##1 !mem_req_q.wr_en)
    else $error("store strobe wrong");
  a_direct_addr: assert property (take &&
    instr.op == FBLS_OP_LD_DIR |=> mem_req_q.addr == $past(instr.addr))
    else $error("direct load address wrong");
  a_move_single: assert property (take &&
    instr.op inside {FBLS_OP_COPY, FBLS_OP_PCOPY, FBLS_OP_IMM}
    |=> instr_ready && !mem_req_q.rd_en)
    else $error("move not single cycle");
  a_busy_once: assert property (busy_q |=> !busy_q)
    else $error("busy longer than one cycle");
endmodule : fbls_exec_props

bind fbls_exec fbls_exec_props #(.PC_W(PC_W)) u_props (
  .clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
  .instr(instr), .sreg(sreg), .mem_rdata(mem_rdata),
  .instr_ready(instr_ready), .pc_q(pc_q), .busy_q(busy_q),
  .mem_req_q(mem_req_q), .dbg_ra_q(dbg_ra_q));

/* File: fbls_mem_model.sv */
// Data memory model answering the executor's read strobes
`timescale 1ns/1ps
module fbls_mem_model
  import fbls_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire fbls_mem_req_t mem_req_q,
  output logic [7:0]         mem_rdata
);
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] idle_q;

  // Content is a function of the address so loads can be predicted.
  // The answer stands in the cycle of the strobe, since the executor
  // writes the byte at the end of that cycle; between reads the bus
  // toggles, so stale data never looks valid
  always_ff @(posedge clock) begin
    if (sys_rst)
      idle_q <= 8'h00;
    else
      idle_q <= ~idle_q;
  end
  assign mem_rdata = mem_req_q.rd_en ?
                     mem_req_q.addr[7:0] ^ mem_req_q.addr[15:8] ^ 8'h5a :
                     idle_q;
endmodule : fbls_mem_model

/* File: fbls_exec_test.sv */
// Self-checking bench for the flag-branch and load-store executor
`timescale 1ns/1ps
module fbls_exec_test;
  import fbls_pkg::*;
  logic          clock;
  logic          sys_rst;
  logic          instr_valid;
  fbls_instr_t   instr;
  logic [7:0]    sreg;
  logic [7:0]    mem_rdata;
  logic          instr_ready;
  logic [15:0]   pc_q;
  logic          busy_q;
  fbls_mem_req_t mem_req_q;
  logic [7:0]    dbg_ra_q;
  logic [15:0]   pcx;
  logic [7:0]    rx [32];
  int            fails;
  int            checks;

  // ----------------------------------------------------------------
  // Design, memory and clock
  // ----------------------------------------------------------------
  fbls_exec uut (.clock(clock), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr(instr), .sreg(sreg),
    .mem_rdata(mem_rdata), .instr_ready(instr_ready), .pc_q(pc_q),
    .busy_q(busy_q), .mem_req_q(mem_req_q), .dbg_ra_q(dbg_ra_q));
  fbls_mem_model mem (.clock(clock), .sys_rst(sys_rst),
    .mem_req_q(mem_req_q), .mem_rdata(mem_rdata));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task results;
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input logic ok, input string m);
    checks++;
    if (!ok) begin
      fails++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk

  // Expected branch decision from the status byte
  function automatic logic br_take(fbls_op_t op, logic [7:0] s);
    logic [11:0] c;
    c = {!s[5], s[5],
         s[2] ^ s[3], !(s[2] ^ s[3]),
         !s[2], s[2],
         s[0], !s[0], !s[0],
         !s[7], s[7], 1'b0};
    return (op >= FBLS_OP_BR_IE && op <= FBLS_OP_BR_HC) ? c[op] : 1'b0;
  endfunction : br_take

  function automatic logic [15:0] ptr(int k);
    return {rx[27 + 2 * k], rx[26 + 2 * k]};
  endfunction : ptr

  // Random instruction, fields kept to the legal pointer forms
  function automatic fbls_instr_t rnd(fbls_op_t op);
    fbls_instr_t i;
    logic [63:0] w;
    w = {$urandom, $urandom};
    i = w[$bits(fbls_instr_t)-1:0];
    i.op = op;
    i.rd = 5'($urandom % 26);
    i.ptr = 2'($urandom % 3);
    i.pmode = fbls_pmode_t'($urandom % 3);
    if (op == FBLS_OP_LD_DISP)
      i.ptr = 2'(1 + $urandom % 2);
    if (op == FBLS_OP_ST_IND) begin
      i.ptr = 2'h0;
      i.pmode = fbls_pmode_t'($urandom % 2);
    end
    return i;
  endfunction : rnd

  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    pcx = 16'h0000;
    foreach (rx[j]) rx[j] = 8'h00;
    @(negedge clock);
    chk(pc_q === 16'h0000 && busy_q === 1'b0, "reset");
    @(posedge clock);
  endtask : do_reset

  // Offer one instruction, check its answer, then update the model
  task automatic issue(input fbls_instr_t i);
    logic [15:0] p;
    logic [15:0] a;
    logic [7:0]  s;
    logic        t;
    logic        m;
    int          k;
    int          n;
    s = 8'($urandom);
    t = br_take(i.op, s);
    m = i.op >= FBLS_OP_LD_IND;
    k = (i.op == FBLS_OP_LD_DISP) ? 1 + i.ptr[1] : i.ptr;
    p = ptr(k) - (i.op == FBLS_OP_LD_IND && i.pmode == FBLS_PM_PRE);
    a = (i.op == FBLS_OP_LD_DIR) ? i.addr :
        p + ((i.op == FBLS_OP_LD_DISP) ? i.imm : 8'h00);
    pcx = pcx + 16'h0001 + (t ? {{9{i.offs[6]}}, i.offs} : 16'h0000);
    instr <= i;
    sreg <= s;
    instr_valid <= 1'b1;
    n = 0;
    @(negedge clock);
    while (instr_ready !== 1'b1 && n < 9) begin
      @(negedge clock);
      n++;
    end
    chk(instr_ready === 1'b1, "not ready to accept");
    @(posedge clock);
    instr_valid <= 1'b0;
    @(negedge clock);
    chk(pc_q === pcx, "pc");
    chk(instr_ready === !(t || m), "ready");
    chk(mem_req_q.rd_en === (m && i.op != FBLS_OP_ST_IND),
        "read");
    chk(mem_req_q.wr_en === (i.op == FBLS_OP_ST_IND), "write");
    if (m)
      chk(mem_req_q.addr === a, "address");
    chk(dbg_ra_q === rx[i.rr], "read port");
    if (i.op == FBLS_OP_ST_IND)
      chk(mem_req_q.wdata === rx[i.rr], "store data");
    case (i.op)
      FBLS_OP_IMM:  rx[i.rd] = i.imm;
      FBLS_OP_COPY: rx[i.rd] = rx[i.rr];
      FBLS_OP_PCOPY: begin
        rx[i.rd] = rx[i.rr];
        rx[i.rd + 1] = rx[i.rr + 1];
      end
      FBLS_OP_LD_IND, FBLS_OP_LD_DISP, FBLS_OP_LD_DIR:
        rx[i.rd] = a[7:0] ^ a[15:8] ^ 8'h5a;
      default: ;
    endcase
    if (i.op == FBLS_OP_LD_IND || i.op == FBLS_OP_ST_IND) begin
      p = p + (i.pmode == FBLS_PM_POST);
      {rx[27 + 2 * k], rx[26 + 2 * k]} = p;
    end
    @(posedge clock);
    if (m)
      @(posedge clock);
  endtask : issue

  task automatic put(input logic [4:0] r, input logic [7:0] v);
    fbls_instr_t i;
    i = rnd(FBLS_OP_IMM);
    i.rd = r;
    i.imm = v;
    issue(i);
  endtask : put

  // Tests need about 5,000 cycles; 20,000 leaves ample margin
  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    fbls_instr_t i;
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    sreg = 8'h00;
    fails = 0;
    checks = 0;
    void'($urandom(58));
    do_reset();
    // Every branch code with random flags and offsets
    for (int j = 0; j < 440; j++)
      issue(rnd(fbls_op_t'(1 + j % 11)));
    // Pointer carry corners: wrap up from ffff and down from 0000
    put(5'h1a, 8'hff);
    put(5'h1b, 8'hff);
    i = rnd(FBLS_OP_LD_IND);
    i.ptr = 2'h0;
    i.pmode = FBLS_PM_POST;
    issue(i);
    i.pmode = FBLS_PM_PLAIN;
    issue(i);
    i.ptr = 2'h2;
    i.pmode = FBLS_PM_PRE;
    issue(i);
    // Random mix of moves, loads and stores
    for (int j = 0; j < 1500; j++) begin
      i = rnd(fbls_op_t'(5'h0c + $urandom % 7));
      if (i.op == FBLS_OP_IMM || i.op == FBLS_OP_COPY)
        i.rd = 5'($urandom);
      if (i.op == FBLS_OP_PCOPY) begin
        i.rd = 5'($urandom) & 5'h1e;
        i.rr = i.rr & 5'h1e;
      end
      issue(i);
    end
    // Reset in mid-run, then the counter restarts from zero
    do_reset();
    issue(rnd(FBLS_OP_BR_LT));
    results();
  end
endmodule : fbls_exec_test
